// ==== src/pil_pkg.sv ====
package pil_pkg;
    // Bus framing
    localparam logic [6:0] PIL_TARGET_ADDR  = 7'h5B;  // Arbitrary default target address
    localparam logic [7:0] PIL_REG_KEY_SEL  = 8'h02;
    localparam logic [7:0] PIL_REG_COMMIT   = 8'h03;
    localparam logic [7:0] PIL_REG_UNLOCK   = 8'h0B;
    localparam logic [7:0] PIL_VAL_UNLOCK_A = 8'hE9;
    localparam logic [7:0] PIL_VAL_UNLOCK_B = 8'hEE;
    localparam logic [7:0] PIL_VAL_UNLOCK_C = 8'hEF;
    localparam logic [7:0] PIL_VAL_KEY      = 8'h07;
    localparam logic [7:0] PIL_VAL_COMMIT   = 8'h01;
    localparam int         PIL_SEQ_LEN_A    = 3;
    localparam int         PIL_SEQ_LEN_B    = 6;
    localparam logic [2:0] PIL_STEP_ZERO    = 3'h0;
    localparam logic [2:0] PIL_STEP_ONE     = 3'h1;
    localparam logic [3:0] PIL_BIT_LAST     = 4'h7;
    localparam logic [3:0] PIL_BIT_ACK      = 4'h8;
    localparam logic [3:0] PIL_BIT_ZERO     = 4'h0;
    // Host timing: 1.25 MHz bus, quarter bit at 125 MHz
    // A quarter must stay well above the target's two-cycle synchroniser lag
    localparam int         PIL_CLK_MHZ      = 125;
    localparam int         PIL_QBIT_NS      = 200;
    localparam int         PIL_QBIT_CYC     = (PIL_QBIT_NS * PIL_CLK_MHZ) / 1000;
    // Host frame: addr+W, reg, data, each with its ack slot
    localparam int         PIL_FRAME_BITS   = 27;
    localparam int         PIL_Q_BITS0      = 2;
    localparam int         PIL_Q_STOP       = PIL_Q_BITS0 + 4 * PIL_FRAME_BITS;
    // Host Wishbone registers
    localparam logic [3:0] PIL_WB_CTRL      = 4'h0;
    localparam logic [3:0] PIL_WB_DATA      = 4'h4;
    localparam logic [3:0] PIL_WB_STATUS    = 4'h8;
    localparam int         PIL_CTRL_GO      = 0;
    localparam int         PIL_CTRL_DIS     = 1;
    localparam int         PIL_CTRL_VAR     = 2;
    localparam int         PIL_ST_BUSY      = 0;
    localparam int         PIL_ST_NACK      = 1;
    localparam int         PIL_ST_DONE      = 2;
endpackage

// ==== src/pil_if.sv ====
`timescale 1ns/1ps
interface pil_if;
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    logic tgt_scl_oe;
    logic tgt_sda_oe;
    logic scl;
    logic sda;
    // Open-drain wired-AND: any enabled low driver pulls the line
    assign scl = !((scl_oe && !scl_o) || tgt_scl_oe);
    assign sda = !((sda_oe && !sda_o) || tgt_sda_oe);
    modport host   (output scl_o, output scl_oe, output sda_o, output sda_oe, input scl, input sda);
    modport target (output tgt_scl_oe, output tgt_sda_oe, input scl, input sda);
endinterface

// ==== src/pil_sync.sv ====
`timescale 1ns/1ps
module pil_sync
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Level
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= 1'b1;
            q_o  <= 1'b1;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ==== src/pil_target.sv ====
`timescale 1ns/1ps
module pil_target
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Strap
    input  wire logic variant_b_i,
    // Bus
    pil_if.target     bus,
    // Status
    output logic      disabled_o,
    output logic      wr_strobe_o,
    output logic [7:0] wr_reg_o,
    output logic [7:0] wr_data_o
);
    import pil_pkg::*;

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;

    pil_sync u_scl (.clk_i(clk_i), .rst_i(rst_i), .d_i(bus.scl), .q_o(scl_s));
    pil_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .d_i(bus.sda), .q_o(sda_s));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    assign start_det = scl_s && sda_d && !sda_s;
    assign stop_det  = scl_s && !sda_d && sda_s;
    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;

    // ----------------------------------------------------------------
    // Byte engine
    // ----------------------------------------------------------------
    typedef enum {PIL_IDLE, PIL_ADDR, PIL_REG, PIL_DATA, PIL_SKIP} pil_state_e;
    pil_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       ack_drive;
    logic       byte_done;
    logic       addr_hit;
    logic       is_write;
    logic       ack_end;

    // Count reaches eight on the rise of the last data bit; the byte is whole on the next fall
    assign byte_done = scl_fall && (bit_cnt == PIL_BIT_ACK);
    assign ack_end   = scl_fall && (bit_cnt == PIL_BIT_ACK + 4'h1);
    // Framing is not tracked: after a start, any byte shaped like our address draws an ack
    assign addr_hit  = (shift[7:1] == PIL_TARGET_ADDR);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || disabled_o || start_det || stop_det)
        begin
            bit_cnt <= PIL_BIT_ZERO;
        end
        else if (scl_rise && bit_cnt < PIL_BIT_ACK)
        begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
        end
        else if (scl_fall && bit_cnt == PIL_BIT_ACK + 4'h1)
        begin
            bit_cnt <= PIL_BIT_ZERO;
        end
        else if (scl_rise && bit_cnt == PIL_BIT_ACK)
        begin
            bit_cnt <= PIL_BIT_ACK + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state       <= PIL_IDLE;
            ack_drive   <= 1'b0;
            is_write    <= 1'b0;
            wr_strobe_o <= 1'b0;
            wr_reg_o    <= 8'h00;
            wr_data_o   <= 8'h00;
        end
        else
        begin
            wr_strobe_o <= 1'b0;
            if (disabled_o)
            begin
                state     <= PIL_IDLE;
                ack_drive <= 1'b0;
            end
            else if (start_det)
            begin
                state     <= PIL_ADDR;
                ack_drive <= 1'b0;
            end
            else if (stop_det)
            begin
                state     <= PIL_IDLE;
                ack_drive <= 1'b0;
            end
            else if (scl_fall && bit_cnt == PIL_BIT_ACK + 4'h1)
            begin
                ack_drive <= 1'b0;
            end
            else if (byte_done)
            begin
                // Last bit sampled on the previous rise; shift holds the full byte
                case (state)
                    PIL_ADDR:
                    begin
                        ack_drive <= addr_hit;
                        is_write  <= !shift[0];
                        state     <= addr_hit ? PIL_REG : PIL_SKIP;
                    end
                    PIL_REG:
                    begin
                        ack_drive <= 1'b1;
                        wr_reg_o  <= shift;
                        state     <= is_write ? PIL_DATA : PIL_SKIP;
                    end
                    PIL_DATA:
                    begin
                        ack_drive   <= 1'b1;
                        wr_data_o   <= shift;
                        wr_strobe_o <= 1'b1;
                        state       <= PIL_SKIP;
                    end
                    PIL_SKIP:
                    begin
                        ack_drive <= addr_hit;
                    end
                    default:
                    begin
                        ack_drive <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Disable sequence watcher
    // ----------------------------------------------------------------
    logic [2:0] step;
    logic [7:0] exp_reg;
    logic [7:0] exp_val;
    logic [2:0] seq_len;
    logic       lock_pend;

    assign seq_len = variant_b_i ? 3'(PIL_SEQ_LEN_B) : 3'(PIL_SEQ_LEN_A);

    always_comb
    begin
        exp_reg = PIL_REG_UNLOCK;
        exp_val = variant_b_i ? PIL_VAL_UNLOCK_B : PIL_VAL_UNLOCK_A;
        case (step)
            3'h0: begin exp_reg = PIL_REG_UNLOCK; exp_val = variant_b_i ? PIL_VAL_UNLOCK_B : PIL_VAL_UNLOCK_A; end
            3'h1, 3'h4: begin exp_reg = PIL_REG_KEY_SEL; exp_val = PIL_VAL_KEY; end
            3'h2, 3'h5: begin exp_reg = PIL_REG_COMMIT; exp_val = PIL_VAL_COMMIT; end
            3'h3: begin exp_reg = PIL_REG_UNLOCK; exp_val = PIL_VAL_UNLOCK_C; end
            default: begin exp_reg = PIL_REG_UNLOCK; exp_val = PIL_VAL_UNLOCK_A; end
        endcase
    end

    // Only power-on reset clears the lock; no bus write can undo it
    // The lock waits for the end of the last ack, so that ack is not cut short
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step       <= PIL_STEP_ZERO;
            lock_pend  <= 1'b0;
            disabled_o <= 1'b0;
        end
        else
        begin
            if (lock_pend && (ack_end || stop_det))
            begin
                disabled_o <= 1'b1;
            end
            if (wr_strobe_o && !lock_pend)
            begin
                if (wr_reg_o == exp_reg && wr_data_o == exp_val)
                begin
                    if (step + PIL_STEP_ONE == seq_len)
                    begin
                        lock_pend <= 1'b1;
                    end
                    step <= step + PIL_STEP_ONE;
                end
                else
                begin
                    step <= PIL_STEP_ZERO;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    assign bus.tgt_sda_oe = ack_drive && !disabled_o;
    assign bus.tgt_scl_oe = 1'b0;
endmodule

// ==== src/pil_host.sv ====
`timescale 1ns/1ps
module pil_host
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Bus
    pil_if.host              bus
);
    import pil_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] data_reg;
    logic [7:0] addr_reg;
    logic       busy;
    logic       nack;
    logic       done;
    logic       go;
    logic       dis_req;
    logic       var_b;
    logic       sda_s;

    pil_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .d_i(bus.sda), .q_o(sda_s));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            data_reg <= 8'h00;
            addr_reg <= 8'h00;
            go       <= 1'b0;
            dis_req  <= 1'b0;
            var_b    <= 1'b0;
        end
        else
        begin
            go       <= 1'b0;
            dis_req  <= 1'b0;
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            begin
                wb_dat_o <= 32'h0;
                if (wb_adr_i == PIL_WB_STATUS)
                    wb_dat_o <= {29'h0, done, nack, busy};
                else if (wb_adr_i == PIL_WB_DATA)
                    wb_dat_o <= {16'h0, addr_reg, data_reg};
                if (wb_we_i && wb_sel_i[0] && wb_adr_i == PIL_WB_DATA)
                    data_reg <= wb_dat_i[7:0];
                if (wb_we_i && wb_sel_i[1] && wb_adr_i == PIL_WB_DATA)
                    addr_reg <= wb_dat_i[15:8];
                if (wb_we_i && wb_sel_i[0] && wb_adr_i == PIL_WB_CTRL && !busy)
                begin
                    go      <= wb_dat_i[PIL_CTRL_GO];
                    dis_req <= wb_dat_i[PIL_CTRL_DIS];
                    var_b   <= wb_dat_i[PIL_CTRL_VAR];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Write sequencer: one or a whole disable run of single-byte writes
    // ----------------------------------------------------------------
    logic [2:0]  wr_idx;
    logic [2:0]  wr_total;
    logic [7:0]  cur_reg;
    logic [7:0]  cur_val;
    logic [26:0] frame;
    logic [6:0]  qidx;
    logic [4:0]  bidx;
    logic [9:0]  qcnt;
    logic        in_seq;

    always_comb
    begin
        cur_reg = addr_reg;
        cur_val = data_reg;
        if (in_seq)
        begin
            case (wr_idx)
                3'h0: begin cur_reg = PIL_REG_UNLOCK; cur_val = var_b ? PIL_VAL_UNLOCK_B : PIL_VAL_UNLOCK_A; end
                3'h1, 3'h4: begin cur_reg = PIL_REG_KEY_SEL; cur_val = PIL_VAL_KEY; end
                3'h2, 3'h5: begin cur_reg = PIL_REG_COMMIT; cur_val = PIL_VAL_COMMIT; end
                3'h3: begin cur_reg = PIL_REG_UNLOCK; cur_val = PIL_VAL_UNLOCK_C; end
                default: begin cur_reg = addr_reg; cur_val = data_reg; end
            endcase
        end
    end

    // Frame bits: addr+W, ack slot, reg, ack slot, data, ack slot
    assign frame = {PIL_TARGET_ADDR, 1'b0, 1'b1, cur_reg, 1'b1, cur_val, 1'b1};
    // Bit number within the frame; each bit spans four phases
    assign bidx  = 5'((qidx - 7'(PIL_Q_BITS0)) >> 2);

    // Four quarter-bit phases per bit, plus start and stop phases
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy       <= 1'b0;
            nack       <= 1'b0;
            done       <= 1'b0;
            in_seq     <= 1'b0;
            wr_idx     <= 3'h0;
            wr_total   <= 3'h0;
            qidx       <= 7'h00;
            qcnt       <= 10'h0;
            bus.scl_o  <= 1'b1;
            bus.sda_o  <= 1'b1;
        end
        else if (!busy)
        begin
            if (go || dis_req)
            begin
                busy     <= 1'b1;
                done     <= 1'b0;
                nack     <= 1'b0;
                in_seq   <= dis_req;
                wr_idx   <= 3'h0;
                wr_total <= dis_req ? (var_b ? 3'(PIL_SEQ_LEN_B) : 3'(PIL_SEQ_LEN_A)) : 3'h1;
                qidx     <= 7'h00;
                qcnt     <= 10'h0;
            end
        end
        else if (qcnt != 10'(PIL_QBIT_CYC - 1))
        begin
            qcnt <= qcnt + 10'h1;
        end
        else
        begin
            qcnt <= 10'h0;
            qidx <= qidx + 7'h01;
            if (qidx == 7'h00)
                bus.sda_o <= 1'b0;
            else if (qidx == 7'h01)
                bus.scl_o <= 1'b0;
            else if (qidx < 7'(PIL_Q_STOP))
            begin
                // Bit phases: set data, raise, sample, lower
                case (qidx[1:0])
                    2'h2: bus.sda_o <= frame[5'(PIL_FRAME_BITS - 1) - bidx];
                    2'h3: bus.scl_o <= 1'b1;
                    2'h0: if (bidx % 5'd9 == 5'd8 && sda_s) nack <= 1'b1;
                    default: bus.scl_o <= 1'b0;
                endcase
            end
            else if (qidx == 7'(PIL_Q_STOP))
                bus.sda_o <= 1'b0;
            else if (qidx == 7'(PIL_Q_STOP + 1))
                bus.scl_o <= 1'b1;
            else
            begin
                // Stop; during the disable run errors are ignored and the run goes on
                bus.sda_o <= 1'b1;
                qidx      <= 7'h00;
                if (wr_idx + 3'h1 == wr_total)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                wr_idx <= wr_idx + 3'h1;
            end
        end
    end

    assign bus.scl_oe = 1'b1;
    assign bus.sda_oe = 1'b1;
endmodule

// ==== test/pil_assertions.sv ====
`timescale 1ns/1ps
module pil_assertions
    import pil_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Host drive
    input  wire logic scl_o,
    input  wire logic scl_oe,
    input  wire logic sda_o,
    input  wire logic sda_oe,
    // Target drive
    input  wire logic tgt_scl_oe,
    input  wire logic tgt_sda_oe,
    // Resolved lines
    input  wire logic scl,
    input  wire logic sda,
    // Target status
    input  wire logic disabled_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Longest legal acknowledge: one bit plus the synchroniser lag, with margin
    localparam int ACK_RUN_MAX = 5 * PIL_QBIT_CYC;
    logic [11:0] oe_run;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !tgt_sda_oe)
        begin
            oe_run <= 12'h000;
        end
        else
        begin
            oe_run <= oe_run + 12'h001;
        end
    end

    // ----------------------------------------
    // Acknowledge slot shape
    // ----------------------------------------
    // A cut acknowledge shows as a short pulse; its upper bound is counted above
    sequence ack_span_s;
        tgt_sda_oe [*8];
    endsequence
    sequence ack_gap_s;
        !tgt_sda_oe [*8];
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    scl_never_a: assert property (!tgt_scl_oe)
        else $error("target drove the clock line");
    dis_quiet_a: assert property (disabled_o |-> !tgt_sda_oe)
        else $error("disabled target pulled the data line");
    dis_sticky_a: assert property (disabled_o |=> disabled_o)
        else $error("disable cleared without reset");
    ack_rise_a: assert property ($rose(tgt_sda_oe) |-> !scl)
        else $error("acknowledge started while clock high");
    ack_hold_a: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe))
        else $error("acknowledge changed while clock high");
    ack_span_a: assert property ($rose(tgt_sda_oe) |-> ack_span_s)
        else $error("acknowledge slot has wrong length");
    ack_bound_a: assert property (oe_run <= ACK_RUN_MAX)
        else $error("acknowledge held past its bit");
    ack_gap_a: assert property ($fell(tgt_sda_oe) |-> ack_gap_s)
        else $error("acknowledge repeated without a byte");
    sda_pull_a: assert property (tgt_sda_oe |-> !sda)
        else $error("data line not low during acknowledge");

    dis_cover: cover property ($rose(disabled_o));
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import pil_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        variant_b_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [3:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        disabled_o;
    logic        wr_strobe_o;
    logic [7:0]  wr_reg_o;
    logic [7:0]  wr_data_o;
    logic        oe_q;
    int          n_ack;
    int          n_strobe;
    int          ack_base;
    int          strobe_base;
    int          n_mismatch;
    int          total_checks;
    logic [31:0] rnd;
    logic [7:0]  rg;

    pil_if bus_if();

    pil_host pil_host_i
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .bus      (bus_if.host)
    );

    pil_target pil_target_i
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .variant_b_i (variant_b_i),
        .bus         (bus_if.target),
        .disabled_o  (disabled_o),
        .wr_strobe_o (wr_strobe_o),
        .wr_reg_o    (wr_reg_o),
        .wr_data_o   (wr_data_o)
    );

    pil_assertions pil_assertions_i
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .scl_o      (bus_if.scl_o),
        .scl_oe     (bus_if.scl_oe),
        .sda_o      (bus_if.sda_o),
        .sda_oe     (bus_if.sda_oe),
        .tgt_scl_oe (bus_if.tgt_scl_oe),
        .tgt_sda_oe (bus_if.tgt_sda_oe),
        .scl        (bus_if.scl),
        .sda        (bus_if.sda),
        .disabled_o (disabled_o)
    );

    // ----------------------------------------
    // Clock and wire monitors
    // ----------------------------------------
    always #4 clk_i = ~clk_i;

    // Counting rises of the target's own data enable, not of the resolved data line
    always @(posedge clk_i)
    begin
        oe_q <= bus_if.tgt_sda_oe;
        if (bus_if.tgt_sda_oe === 1'b1 && oe_q === 1'b0)
            n_ack <= n_ack + 1;
        if (wr_strobe_o === 1'b1)
            n_strobe <= n_strobe + 1;
    end

    // ----------------------------------------
    // Tasks and functions
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
            begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
            end
    endtask

    function automatic logic [31:0] st_exp(input logic nack);
        st_exp = 32'h0;
        st_exp[PIL_ST_DONE] = 1'b1;
        st_exp[PIL_ST_NACK] = nack;
    endfunction

    function automatic int acks_exp(input int writes, input logic en);
        acks_exp = en ? 3 * writes : 0;
    endfunction

    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_sel_i <= 4'hF;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Only the watchdog ends a wait for the acknowledge
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Polls status until idle, then checks target ack enables, status and idle lines
    task automatic finish_op(input int acks, input logic [31:0] st);
        logic [31:0] q;
        q = 32'h1;
        while (q[PIL_ST_BUSY] !== 1'b0)
        begin
            wb(PIL_WB_STATUS, 1'b0, 32'h0, q);
        end
        repeat (4) @(posedge clk_i);
        check(n_ack - ack_base, acks);
        check(q & 32'h7, st);
        check({30'h0, bus_if.scl, bus_if.sda}, 32'h3);
    endtask

    task automatic i2c_write(input logic [7:0] r, input logic [7:0] d, input logic en);
        logic [31:0] q;
        ack_base = n_ack;
        strobe_base = n_strobe;
        wb(PIL_WB_DATA, 1'b1, {16'h0, r, d}, q);
        wb(PIL_WB_CTRL, 1'b1, 32'h1 << PIL_CTRL_GO, q);
        finish_op(acks_exp(1, en), st_exp(!en));
        check(n_strobe - strobe_base, {31'h0, en});
        if (en)
            check({16'h0, wr_reg_o, wr_data_o}, {16'h0, r, d});
    endtask

    task automatic run_seq(input logic varb);
        logic [31:0] q;
        ack_base = n_ack;
        wb(PIL_WB_CTRL, 1'b1, (32'h1 << PIL_CTRL_DIS) | ({31'h0, varb} << PIL_CTRL_VAR), q);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    // Seventeen bus writes of about 2.8k cycles each, plus margin
    initial
    begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        variant_b_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        oe_q = 1'b0;
        n_ack = 0;
        n_strobe = 0;
        n_mismatch = 0;
        total_checks = 0;
        void'($urandom(32'h0C6E97C1));
        do_reset();
        check({31'h0, disabled_o}, 32'h0);
        rnd = $urandom;
        rg = (rnd[15:8] == PIL_REG_UNLOCK) ? 8'h0C : rnd[15:8];
        i2c_write(rg, rnd[7:0], 1'b1);
        i2c_write({PIL_TARGET_ADDR, 1'b0}, {PIL_TARGET_ADDR, 1'b0}, 1'b1);
        $display("test single_writes done");
        i2c_write(PIL_REG_UNLOCK, PIL_VAL_UNLOCK_A, 1'b1);
        i2c_write(PIL_REG_KEY_SEL, PIL_VAL_KEY ^ (8'h01 << $urandom_range(7, 0)), 1'b1);
        i2c_write(PIL_REG_COMMIT, PIL_VAL_COMMIT, 1'b1);
        check({31'h0, disabled_o}, 32'h0);
        $display("test wrong_key done");
        run_seq(1'b0);
        finish_op(acks_exp(PIL_SEQ_LEN_A, 1'b1), st_exp(1'b0));
        check({31'h0, disabled_o}, 32'h1);
        $display("test disable_three done");
        // Repeating the sequence on a dead target must still run to the end
        run_seq(1'b0);
        finish_op(acks_exp(PIL_SEQ_LEN_A, 1'b0), st_exp(1'b1));
        check({31'h0, disabled_o}, 32'h1);
        $display("test disabled_silent done");
        variant_b_i <= 1'b1;
        do_reset();
        check({31'h0, disabled_o}, 32'h0);
        run_seq(1'b1);
        finish_op(acks_exp(PIL_SEQ_LEN_B, 1'b1), st_exp(1'b0));
        check({31'h0, disabled_o}, 32'h1);
        $display("test disable_six done");
        give_verdict();
    end
endmodule
